// ==== src/expander_pkg.sv ====
package expander_pkg;
  // ==========================================
  // Clock and timing
  // ==========================================
  localparam int CLK_PERIOD_NS = 50;
  localparam int SPIKE_NS = 50;
  // Pulses up to this many cycles are swallowed by the filter
  localparam int SPIKE_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W = 2;
  localparam int NS_PER_MS = 1000000;
  localparam int STALL_MIN_MS = 29;
  localparam int STALL_MAX_MS = 61;
  localparam int STALL_CYCLES = STALL_MIN_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int STALL_W = 21;

  // ==========================================
  // Bus geometry
  // ==========================================
  localparam int LINES = 2;
  localparam int LINE_SCL = 0;
  localparam int LINE_SDA = 1;
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam logic [BIT_CNT_W-1:0] LAST_TX_BIT = 4'h7;
  localparam int SEL_W = 2;
  localparam logic [BYTE_W-1:0] IDLE_FILL = 8'hFF;
  localparam logic [BYTE_W-1:0] SELECT_RESET = 8'h00;

  // ==========================================
  // Port lines and buffering
  // ==========================================
  localparam int PORT_LINES = 16;
  localparam logic [PORT_LINES-1:0] PORT_ALL_INPUT = 16'hFFFF;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 8;

  typedef enum {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK, ST_SKIP
  } link_state_t;

  typedef enum {
    KIND_ADDR, KIND_SELECT, KIND_DATA
  } byte_kind_t;
endpackage

// ==== src/byte_fifo.sv ====
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input logic clock,
  input logic sys_rst,
  input logic inValid,
  output logic inReady,
  input logic [WIDTH-1:0] inData,
  output logic outValid,
  input logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_COUNT = DEPTH[PTR_W:0];

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0] fill;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;

  // ==========================================
  // Flags
  // ==========================================
  // Honest flags straight from the fill count
  assign inReady = (fill != FULL_COUNT);
  assign outValid = (fill != '0);
  assign outData = store[rdPtr];

  // ==========================================
  // Storage and pointers
  // ==========================================
  // Write side
  always_ff @(posedge clock)
  begin
    if (doPush)
      store[wrPtr] <= inData;
  end

  // Pointers wrap naturally since depth is a power of two
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr <= wrPtr + 1'b1;
      if (doPop)
        rdPtr <= rdPtr + 1'b1;
      if (doPush && !doPop)
        fill <= fill + 1'b1;
      else if (doPop && !doPush)
        fill <= fill - 1'b1;
    end
  end
endmodule

// ==== src/two_wire_expander_slave_front_end.sv ====
// What this block does
// RULE1 - Either line low past the stall limit resets the serial logic.
// RULE2 - Stall timeout can be switched off by an enable input.
// RULE3 - Master keeps clocking so lines never stay low past the limit.
// RULE4 - Pulses shorter than 50 ns on either line are filtered out.
// RULE5 - All 16 port lines are inputs after power-up.
// RULE6 - Three select inputs choose one of 64 slave addresses.
// RULE7 - Device is slave only and never drives the clock line.
// RULE8 - Master starts every transfer and makes every clock pulse.
// RULE9 - START, address plus direction, select byte, data bytes, STOP.
// RULE10 - Both lines stay released and high when the bus is idle.
// RULE11 - Data falling while clock high is START; a transaction begins.
// RULE12 - Data rising while clock high is STOP; bus is then free.
// RULE13 - Direction bit low requests write, high requests read.
// RULE14 - Receiver holds data low through the ninth clock high period.
// RULE15 - Data changes only while clock is low, except START and STOP.
// RULE16 - First written byte after address is the register selector.
// RULE17 - Unmatched address is not acknowledged; line stays released.
// RULE18 - Stall reset releases data, drops partial byte, awaits START.
`timescale 1ns/1ps
module two_wire_expander_slave_front_end #(
  parameter int STALL_LIMIT = expander_pkg::STALL_CYCLES,
  parameter logic ADDR_TOP = 1'b0
) (
  input logic clock,
  input logic sys_rst,
  input logic sclIn,
  input logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input logic [expander_pkg::SEL_W-1:0] addr_select_0,
  input logic [expander_pkg::SEL_W-1:0] addr_select_1,
  input logic [expander_pkg::SEL_W-1:0] addr_select_2,
  input logic stallTimeoutEnable,
  output logic stallReset,
  output logic busBusy,
  output logic [expander_pkg::PORT_LINES-1:0] portLinesInput,
  output logic [expander_pkg::BYTE_W-1:0] regSelect,
  output logic regSelectValid,
  output logic wrValid,
  input logic wrReady,
  output logic [expander_pkg::BYTE_W-1:0] wrData,
  input logic [expander_pkg::BYTE_W-1:0] rdData,
  input logic rdValid,
  output logic rdTake
);
  import expander_pkg::*;

  // ==========================================
  // Line synchronisers and spike filters
  // ==========================================
  wire [LINES-1:0] rawLine = {sdaIn, sclIn};
  logic [2:0] syncChain [LINES];
  logic [FILT_W-1:0] filtCount [LINES];
  logic [LINES-1:0] lineLevel;

  // Three flops, then a level must hold past the spike width
  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : gen_line
      wire agreed = (syncChain[g][1] == syncChain[g][2]);
      wire differs = agreed && (syncChain[g][2] != lineLevel[g]);
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          syncChain[g] <= 3'h7;
          filtCount[g] <= '0;
          lineLevel[g] <= 1'b1;
        end
        else
        begin
          syncChain[g] <= {syncChain[g][1:0], rawLine[g]};
          if (!differs)
            filtCount[g] <= '0;
          else if (filtCount[g] == FILT_W'(SPIKE_CYCLES)) // RULE4
          begin
            lineLevel[g] <= syncChain[g][2];
            filtCount[g] <= '0;
          end
          else
            filtCount[g] <= filtCount[g] + 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================
  // Bus events
  // ==========================================
  logic sclPrev;
  logic sdaPrev;
  wire sclLine = lineLevel[LINE_SCL];
  wire sdaLine = lineLevel[LINE_SDA];
  wire sclRise = sclLine && !sclPrev;
  wire sclFall = !sclLine && sclPrev;
  wire startSeen = sclLine && sclPrev && sdaPrev && !sdaLine; // RULE11
  wire stopSeen = sclLine && sclPrev && !sdaPrev && sdaLine; // RULE12

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclPrev <= sclLine;
      sdaPrev <= sdaLine;
    end
  end

  // ==========================================
  // Slave address
  // ==========================================
  // Each select pin has four strap states, so six bits of address
  function automatic logic [6:0] slaveAddr(
    input logic [SEL_W-1:0] s2,
    input logic [SEL_W-1:0] s1,
    input logic [SEL_W-1:0] s0);
    slaveAddr = {ADDR_TOP, s2, s1, s0};
  endfunction

  logic [6:0] myAddr;
  // Straps are static but taken through a flop to stay in domain
  always_ff @(posedge clock)
  begin
    myAddr <= slaveAddr(addr_select_2, addr_select_1, addr_select_0); // RULE6
  end

  // ==========================================
  // Stall timeout
  // ==========================================
  logic [STALL_W-1:0] stallCount [LINES];
  logic [LINES-1:0] stallHitLine;
  wire lineLow = !sclLine || !sdaLine;
  wire stallHit = |stallHitLine;

  // One counter per line: normal traffic keeps one line or the other
  // low nearly all the time, so only an unbroken low on one line counts
  generate
    for (g = 0; g < LINES; g++)
    begin : gen_stall
      assign stallHitLine[g] = stallCount[g] == STALL_W'(STALL_LIMIT - 1);
      // Off when disabled, so a master may park the clock forever
      always_ff @(posedge clock)
      begin
        if (sys_rst || stallReset)
          stallCount[g] <= '0;
        else if (!stallTimeoutEnable || lineLevel[g]) // RULE2
          stallCount[g] <= '0;
        else
          stallCount[g] <= stallCount[g] + 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      stallReset <= 1'b0;
    else
      stallReset <= stallTimeoutEnable && stallHit; // RULE1
  end

  // ==========================================
  // Protocol engine
  // ==========================================
  link_state_t state;
  byte_kind_t kind;
  logic [BIT_CNT_W-1:0] bitCount;
  logic [BYTE_W-1:0] rxShift;
  logic [BYTE_W-1:0] txShift;
  logic readMode;
  logic masterAck;
  logic pushByte;
  logic [BYTE_W-1:0] pushData;
  logic fifoReady;

  wire byteDone = sclFall && (bitCount == BITS_PER_BYTE);
  wire addrMatch = (rxShift[7:1] == myAddr); // RULE17
  wire isRead = rxShift[0]; // RULE13
  // Full buffer refuses the byte by a NACK; the clock is never held
  wire ackIt = (kind == KIND_ADDR) ? addrMatch :
               (kind == KIND_DATA) ? fifoReady : 1'b1;
  wire [BYTE_W-1:0] nextTx = rdValid ? rdData : IDLE_FILL;
  wire txDone = sclFall && (bitCount == LAST_TX_BIT);

  // Bus reset events win over everything; data only moves on a fall
  always_ff @(posedge clock)
  begin
    pushByte <= 1'b0;
    regSelectValid <= 1'b0;
    rdTake <= 1'b0;
    if (sys_rst || stallReset || stopSeen) // RULE18 RULE12
    begin
      state <= ST_IDLE;
      sdaOe <= 1'b0; // RULE10
      kind <= KIND_ADDR;
      bitCount <= '0;
      if (sys_rst)
      begin
        regSelect <= SELECT_RESET;
        readMode <= 1'b0;
        masterAck <= 1'b0;
        rxShift <= '0;
        txShift <= '0;
        pushData <= '0;
      end
    end
    else if (startSeen) // RULE11
    begin
      state <= ST_RX;
      kind <= KIND_ADDR;
      bitCount <= '0;
      sdaOe <= 1'b0;
    end
    else
    begin
      case (state)
        ST_RX:
        begin
          if (sclRise)
          begin
            rxShift <= {rxShift[6:0], sdaLine};
            bitCount <= bitCount + 1'b1;
          end
          else if (byteDone && ackIt) // RULE9
          begin
            state <= ST_ACK;
            sdaOe <= 1'b1; // RULE14
            if (kind == KIND_ADDR)
              readMode <= isRead;
            if (kind == KIND_SELECT)
            begin
              regSelect <= rxShift; // RULE16
              regSelectValid <= 1'b1;
            end
            if (kind == KIND_DATA)
            begin
              pushByte <= 1'b1;
              pushData <= rxShift;
            end
          end
          else if (byteDone)
            state <= ST_SKIP; // RULE17
        end
        ST_ACK:
        begin
          if (sclFall) // RULE15
          begin
            bitCount <= '0;
            if (kind == KIND_ADDR && readMode)
            begin
              state <= ST_TX;
              txShift <= nextTx;
              rdTake <= rdValid;
              sdaOe <= !nextTx[7];
            end
            else
            begin
              state <= ST_RX;
              sdaOe <= 1'b0;
              kind <= (kind == KIND_ADDR) ? KIND_SELECT : KIND_DATA;
            end
          end
        end
        ST_TX:
        begin
          if (txDone)
          begin
            state <= ST_RACK;
            sdaOe <= 1'b0;
          end
          else if (sclFall) // RULE15
          begin
            bitCount <= bitCount + 1'b1;
            txShift <= {txShift[6:0], 1'b0};
            sdaOe <= !txShift[6];
          end
        end
        ST_RACK:
        begin
          if (sclRise)
            masterAck <= !sdaLine;
          else if (sclFall && masterAck)
          begin
            state <= ST_TX;
            bitCount <= '0;
            txShift <= nextTx;
            rdTake <= rdValid;
            sdaOe <= !nextTx[7];
          end
          else if (sclFall)
            state <= ST_SKIP;
        end
        default:
          state <= state;
      endcase
    end
  end

  // ==========================================
  // Outputs and write buffer
  // ==========================================
  assign sdaOut = 1'b0; // RULE7
  assign busBusy = (state != ST_IDLE);

  // Direction control is held here until the register file takes over
  always_ff @(posedge clock)
  begin
    portLinesInput <= PORT_ALL_INPUT; // RULE5
  end

  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .inValid(pushByte),
    .inReady(fifoReady),
    .inData(pushData),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrData)
  );

  // ==========================================
  // Assertions
  // ==========================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  stall_reset_a: assert property ( // RULE1
    stallTimeoutEnable && lineLow && stallHit |=> stallReset ##1
    (state == ST_IDLE && !sdaOe))
    else $error("stall did not reset the interface");
  stall_off_a: assert property ( // RULE2
    stallReset |-> $past(stallTimeoutEnable))
    else $error("stall reset while timeout disabled");
  spike_filter_a: assert property ( // RULE4
    $changed(sclLine) |-> $past(syncChain[LINE_SCL][2], 2) == sclLine)
    else $error("clock level changed on a short pulse");
  port_input_a: assert property ( // RULE5
    ##1 portLinesInput == PORT_ALL_INPUT)
    else $error("port line not an input");
  slave_drive_a: assert property ( // RULE7
    sdaOe |-> state inside {ST_ACK, ST_TX, ST_RACK})
    else $error("data driven outside ack or send");
  start_detect_a: assert property ( // RULE11
    startSeen && !stallReset |=> state == ST_RX && bitCount == '0)
    else $error("start not taken");
  stop_free_a: assert property ( // RULE12
    stopSeen |=> state == ST_IDLE && !sdaOe && !busBusy)
    else $error("stop did not free the bus");
  ack_hold_a: assert property ( // RULE14
    state == ST_ACK && sdaOe && sclRise |-> sdaOe throughout
    (##[1:300] sclFall))
    else $error("ack released during clock high");
  sda_change_a: assert property ( // RULE15
    $changed(sdaOe) |-> $past(sclFall) || $past(startSeen) ||
    $past(stopSeen) || $past(stallReset) || $past(byteDone))
    else $error("data changed outside clock low");
  select_latch_a: assert property ( // RULE16
    $changed(regSelect) |-> regSelectValid && $past(kind == KIND_SELECT))
    else $error("selector taken from wrong byte");
  no_match_a: assert property ( // RULE17
    state == ST_SKIP |-> !sdaOe)
    else $error("unmatched address driven");

  write_seen_c: cover property (pushByte ##[1:1000] stopSeen);
  read_seen_c: cover property (rdTake ##[1:1000] state == ST_RACK);
  stall_seen_c: cover property (stallReset);
  nack_seen_c: cover property (byteDone && !ackIt && kind == KIND_DATA);
endmodule

// ==== test/bus_master_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Bus master model
// ==========================================
// Behavioural master; owns the clock line, data released to the pull-up
module bus_master_model #(
  parameter int Q = 400
) (
  output logic scl,
  output logic sda,
  input wire logic sdaWire
);
  // Both lines released while idle
  initial
  begin
    scl = 1'h1;
    sda = 1'h1;
  end

  // Data falls with clock high
  task automatic start();
    #Q sda = 1'h0;
    #Q scl = 1'h0;
  endtask

  // Data rises with clock high, then bus left free
  task automatic stop();
    #Q sda = 1'h0;
    #Q scl = 1'h1;
    #Q sda = 1'h1;
    #(2*Q);
  endtask

  // One clock pulse; data moves only while clock is low
  task automatic pulse(input logic d, output logic s);
    #Q sda = d;
    #Q scl = 1'h1;
    #Q s = sdaWire;
    #Q scl = 1'h0;
  endtask

  // Byte out MSB first, ninth clock samples the answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'h1, s);
    ack = (s === 1'h0);
  endtask

  // Eight bits in; the caller clocks its own acknowledge
  task automatic rbyte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'h1, s);
      b[i] = s;
    end
  endtask

  // Too short to count; would look like a START if unfiltered
  task automatic spike();
    #Q sda = 1'h0;
    #40 sda = 1'h1;
    #Q;
  endtask
endmodule

// ==== test/test_two_wire_expander_slave_front_end.sv ====
`timescale 1ns/1ps
module test_two_wire_expander_slave_front_end;
  import expander_pkg::*;
  // Short stall limit keeps the run brief
  localparam int LIMIT = 200;
  localparam logic [6:0] MY = 7'h1B;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic scl, sdaM, sdaWire, sdaOut, sdaOe, ack, s;
  logic stallTimeoutEnable = 1'h0;
  logic stallReset, busBusy, regSelectValid, wrValid, rdTake;
  logic wrReady = 1'h0;
  logic rdValid = 1'h0;
  logic [7:0] rdData = 8'h00;
  logic [7:0] regSelect, wrData, b;
  logic [15:0] portLinesInput;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int sels = 0;
  int stalls = 0;
  int takes = 0;

  // Open-drain data line with pull-up
  assign sdaWire = sdaM & ~sdaOe;

  two_wire_expander_slave_front_end #(
    .STALL_LIMIT(LIMIT),
    .ADDR_TOP(1'h0)
  ) DUT (
    .clock(clock),
    .sys_rst(sys_rst),
    .sclIn(scl),
    .sdaIn(sdaWire),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .addr_select_0(2'h3),
    .addr_select_1(2'h2),
    .addr_select_2(2'h1),
    .stallTimeoutEnable(stallTimeoutEnable),
    .stallReset(stallReset),
    .busBusy(busBusy),
    .portLinesInput(portLinesInput),
    .regSelect(regSelect),
    .regSelectValid(regSelectValid),
    .wrValid(wrValid),
    .wrReady(wrReady),
    .wrData(wrData),
    .rdData(rdData),
    .rdValid(rdValid),
    .rdTake(rdTake)
  );

  bus_master_model M (
    .scl(scl),
    .sda(sdaM),
    .sdaWire(sdaWire)
  );

  initial
  begin
    forever #25 clock = ~clock;
  end

  // ==========================================
  // Pulse counters and hang guard
  // ==========================================
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    sels <= sels + int'(regSelectValid === 1'h1);
    stalls <= stalls + int'(stallReset === 1'h1);
    takes <= takes + int'(rdTake === 1'h1);
    if (cycles == 30000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic reset_values();
    chk(portLinesInput, 16'hFFFF);
    chk(sdaOe, 1'h0);
    chk(busBusy, 1'h0);
    chk(sdaOut, 1'h0);
  endtask

  // Select byte, then data until the 4-word buffer refuses
  task automatic write_fill();
    logic [7:0] d;
    @(negedge clock);
    M.start();
    M.wbyte({MY, 1'h0}, ack);
    chk(ack, 1'h1);
    chk(busBusy, 1'h1);
    M.wbyte(8'h06, ack);
    chk(ack, 1'h1);
    chk(regSelect, 8'h06);
    chk(16'(sels), 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
      d = 8'(8'h11 * (i + 1));
      M.wbyte(d, ack);
      chk(ack, 1'(i < FIFO_DEPTH));
    end
    M.stop();
    chk(busBusy, 1'h0);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      @(negedge clock);
      chk(wrValid, 1'h1);
      chk(wrData, 8'(8'h11 * (i + 1)));
      @(posedge clock) wrReady <= 1'h1;
      @(posedge clock) wrReady <= 1'h0;
    end
    @(negedge clock);
    chk(wrValid, 1'h0);
  endtask

  // Foreign address: no answer, rest of frame ignored
  task automatic wrong_addr();
    @(negedge clock);
    M.start();
    M.wbyte({7'h1C, 1'h0}, ack);
    chk(ack, 1'h0);
    M.wbyte(8'h00, ack);
    chk(ack, 1'h0);
    chk(16'(sels), 16'h0001);
    M.stop();
  endtask

  // Offered byte, then nothing offered so the idle fill goes out
  task automatic read_two();
    @(posedge clock)
    begin
      rdValid <= 1'h1;
      rdData <= 8'h5A;
    end
    @(negedge clock);
    M.start();
    M.wbyte({MY, 1'h1}, ack);
    chk(ack, 1'h1);
    M.rbyte(b);
    chk(b, 8'h5A);
    @(posedge clock) rdValid <= 1'h0;
    @(negedge clock);
    M.pulse(1'h0, s);
    M.rbyte(b);
    chk(b, IDLE_FILL);
    M.pulse(1'h1, s);
    M.stop();
    chk(16'(takes), 16'h0001);
  endtask

  // Clock held low mid-byte with the timeout armed
  task automatic stall_on();
    @(posedge clock) stallTimeoutEnable <= 1'h1;
    @(negedge clock);
    M.start();
    repeat (3) M.pulse(1'h1, s);
    repeat (LIMIT - 20) @(negedge clock);
    chk(16'(stalls), 16'h0000);
    repeat (120) @(negedge clock);
    chk(16'(stalls), 16'h0001);
    chk(busBusy, 1'h0);
    chk(sdaOe, 1'h0);
    chk(regSelect, 8'h06);
    M.stop();
    M.start();
    M.wbyte({MY, 1'h0}, ack);
    chk(ack, 1'h1);
    M.wbyte(8'hA3, ack);
    chk(regSelect, 8'hA3);
    M.stop();
  endtask

  // Timeout off: a long static clock is harmless
  task automatic stall_off();
    @(posedge clock) stallTimeoutEnable <= 1'h0;
    @(negedge clock);
    M.start();
    repeat (2 * LIMIT) @(negedge clock);
    chk(16'(stalls), 16'h0001);
    chk(busBusy, 1'h1);
    M.stop();
    chk(busBusy, 1'h0);
  endtask

  task automatic glitch();
    @(negedge clock);
    M.spike();
    repeat (10) @(negedge clock);
    chk(busBusy, 1'h0);
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    reset_values();
    write_fill();
    wrong_addr();
    read_two();
    stall_on();
    stall_off();
    glitch();
    test_done();
  end
endmodule
